// ==== ict_sequencer.sv ====
/*
  Instruction cycle timing sequencer. Accepts one issued instruction
  class at a time, runs an optional save step and then the operation
  step, counting clocks, and reports the head/tail overlap to the next
  instruction. Assumes the outside bus answers in two clocks; a bus
  wait input stretches the count for every class but stretch-tolerant
  multi-register transfers.
*/
// Function
// - One bus cycle per byte or word, two per long operand.
// - Long operands add two clocks to tail and total for ALU into memory and bounds compare.
// - Register ALU ops: two clocks, one prefetch, no reads or writes.
// - ALU into memory: five clocks, tail three, size-based writes.
// - Word multiply: twenty-six clocks plus operand fetch time.
// - Signed and unsigned multiply take equal time; unsigned table lookup takes longer than signed.
// - Long multiply step 46 to 52 clocks, 46 for 64-bit result.
// - Word divide: 32 clocks unsigned, 42 signed.
// - Long divide step at most 46 unsigned, 62 signed.
// - Long mul/div and bounds compare: three-clock save first.
// - Skip save for long mul/div with data register source.
// - Decimal: four clocks registers, twelve predecremented memory.
// - Extended memory ten clocks; postincrement compare eight clocks.
// - Test-and-set: ten clocks memory, six clocks register.
// - Immediate and single-bit memory shifts take six clocks.
// - Marked transfers tolerate four-clock bus cycles without slowing.
// - Register table interpolation 28-30, 30-34, 34-40 clocks.
// - Bounds compare step 16 to 18 clocks after save.
// - Immediate ALU ops add immediate operand fetch time.
// - Register shift: max of six and three plus count plus parity.
`timescale 1ns/1ps
module ict_sequencer
  import ict_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       issue_i,
  input  wire logic [4:0] class_i,
  input  wire logic       long_op_i,
  input  wire logic       src_data_reg_i,
  input  wire logic       mem_form_i,
  input  wire logic [5:0] shift_count_i,
  input  wire logic [6:0] data_extra_i,
  input  wire logic [6:0] ea_clocks_i,
  input  wire logic [6:0] imm_clocks_i,
  input  wire logic [3:0] reg_count_i,
  input  wire logic       bus_wait_i,
  output logic            ready_o,
  output logic            busy_o,
  output logic            save_step_o,
  output logic            done_o,
  output logic [7:0]      total_o,
  output logic [6:0]      head_o,
  output logic [6:0]      tail_o,
  output logic [1:0]      reads_o,
  output logic [1:0]      prefetch_o,
  output logic [4:0]      writes_o
);

  ict_state_t state_reg, state_next;
  ict_class_t cls_reg, cls_next;
  logic       long_reg, long_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [6:0] extra_reg, extra_next;
  logic [3:0] nregs_reg, nregs_next;

  logic [6:0] pre_reg, pre_next;
  logic [7:0] left_reg, left_next;
  logic [7:0] acc_reg, acc_next;
  logic [6:0] prev_tail_reg, prev_tail_next;
  logic [1:0] stretch_reg, stretch_next;

  logic       ready_reg, ready_next;
  logic       done_reg, done_next;
  logic [7:0] tot_out_reg, tot_out_next;
  logic [6:0] head_reg, head_next;
  logic [6:0] tail_reg, tail_next;
  logic [1:0] rd_reg, rd_next;
  logic [1:0] pf_reg, pf_next;
  logic [4:0] wr_reg, wr_next;
  // Status pins get their own flops, not decodes
  logic       busy_reg, busy_next;
  logic       save_reg, save_next;
  logic       loaded_reg, loaded_next;

  logic [6:0] c_head;
  logic [6:0] c_tail;
  logic [6:0] c_total;
  logic [1:0] c_reads;
  logic [1:0] c_pref;
  logic [4:0] c_writes;

  // Classes that carry a save step before the operation step
  function automatic logic needs_save(input ict_class_t c,
                                      input logic src_dreg);
    logic ld;
    ld = (c == IC_LONG_MUL32) || (c == IC_LONG_MUL64) ||
         (c == IC_LONG_UDIV) || (c == IC_LONG_SDIV);
    // Long mul/div with a data register source carry no save step
    needs_save = (ld && !src_dreg) ||
                 (c == IC_BOUNDS_CMP);
  endfunction

  // Immediate-source ALU classes take the immediate fetch on top
  function automatic logic is_alu(input ict_class_t c);
    is_alu = (c == IC_REG_ALU) || (c == IC_MEM_ALU);
  endfunction

  // Saturating overlap of previous tail against the new head
  function automatic logic [6:0] overlap(input logic [6:0] t,
                                         input logic [6:0] h);
    overlap = (t < h) ? t : h;
  endfunction

  // Calculator reads latched fields only, so figures hold steady
  ict_calc u_calc (
    .cls_i    (cls_reg),
    .long_i   (long_reg),
    .count_i  (cnt_reg),
    .extra_i  (extra_reg),
    .nregs_i  (nregs_reg),
    .head_o   (c_head),
    .tail_o   (c_tail),
    .total_o  (c_total),
    .reads_o  (c_reads),
    .pref_o   (c_pref),
    .writes_o (c_writes)
  );

  // Sequencer next state: latch, optional save, count operation step
  always_comb begin
    state_next     = state_reg;
    cls_next       = cls_reg;
    long_next      = long_reg;
    cnt_next       = cnt_reg;
    extra_next     = extra_reg;
    nregs_next     = nregs_reg;
    pre_next       = pre_reg;
    left_next      = left_reg;
    acc_next       = acc_reg;
    prev_tail_next = prev_tail_reg;
    stretch_next   = stretch_reg;
    ready_next     = ready_reg;
    done_next      = 1'b0;
    tot_out_next   = tot_out_reg;
    head_next      = head_reg;
    tail_next      = tail_reg;
    rd_next        = rd_reg;
    pf_next        = pf_reg;
    wr_next        = wr_reg;
    loaded_next    = loaded_reg;

    case (state_reg)
      ICT_IDLE: begin
        // Issues made while busy are never looked at
        if (issue_i) begin
          cls_next   = ict_class_t'(class_i);
          long_next  = long_op_i;
          // Counts past the formula's reach saturate at its top
          cnt_next   = (shift_count_i > SHIFT_MAX_CNT) ? SHIFT_MAX_CNT
                                                       : shift_count_i;
          extra_next = data_extra_i;
          nregs_next = reg_count_i;

          // Operand fetch, plus immediate fetch for immediate sources
          pre_next   = ea_clocks_i +
                       ((is_alu(ict_class_t'(class_i)) && mem_form_i)
                        ? imm_clocks_i : 7'h00);
          ready_next = 1'b0;
          acc_next   = 8'h00;
          if (needs_save(ict_class_t'(class_i), src_data_reg_i)) begin
            state_next = ICT_SAVE;
            left_next  = {1'b0, SAVE_TOTAL};
          end else begin
            state_next = ICT_OPER;
            left_next  = 8'h00;
          end
        end
      end

      ICT_SAVE: begin
        // Fixed length: bus waits never stretch the save step
        acc_next  = acc_reg + 8'h01;
        left_next = left_reg - 8'h01;
        if (left_reg == 8'h01) begin
          state_next = ICT_OPER;
          left_next  = 8'h00;
        end
      end

      ICT_OPER: begin
        // First cycle loads the figure: address + step - overlap
        if (left_reg == 8'h00 && !loaded_reg) begin
          left_next = {1'b0, c_total} + {1'b0, pre_reg} -
                      {1'b0, overlap(prev_tail_reg, c_head)};
          // Overlap may cancel the figure; keep one counted clock
          if (left_next == 8'h00)
            left_next = 8'h01;
          head_next    = c_head;
          tail_next    = c_tail;
          rd_next      = c_reads;
          pf_next      = c_pref;
          wr_next      = c_writes;
          tot_out_next = 8'h00;
          loaded_next  = 1'b1;
          stretch_next = 2'd0;
        end else begin
          // Slow bus stretches; stretch-tolerant transfers absorb waits
          if (bus_wait_i && cls_reg == IC_MOVEM_STRETCH &&
              stretch_reg < 2'(STRETCH_CLKS - BUS_CLKS)) begin
            stretch_next = stretch_reg + 2'd1;
            left_next    = left_reg - 8'h01;
          end else if (bus_wait_i && cls_reg != IC_MOVEM_STRETCH) begin
            left_next = left_reg;
          end else begin
            stretch_next = 2'd0;
            left_next    = left_reg - 8'h01;
          end
          // Stalled clocks still count, so total_o is the real length
          acc_next = acc_reg + 8'h01;
          if (left_next == 8'h00) begin
            // Finish: the tail is handed on to overlap the next head
            state_next     = ICT_IDLE;
            done_next      = 1'b1;
            ready_next     = 1'b1;
            tot_out_next   = acc_reg + 8'h01;
            prev_tail_next = tail_reg;
            loaded_next    = 1'b0;
          end
        end
      end

      default: state_next = ICT_IDLE;
    endcase

    // Registered status, so no decode glitch reaches the pins
    busy_next = !ready_next;
    save_next = (state_next == ICT_SAVE);
  end

  // State registers
  // Reset leaves the sequencer idle and ready to take an issue
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg     <= ICT_IDLE;
      cls_reg       <= IC_REG_ALU;
      long_reg      <= 1'b0;
      cnt_reg       <= 6'h00;
      extra_reg     <= 7'h00;
      nregs_reg     <= 4'h0;
      pre_reg       <= 7'h00;
      left_reg      <= 8'h00;
      acc_reg       <= 8'h00;
      prev_tail_reg <= 7'h00;
      stretch_reg   <= 2'h0;
      ready_reg     <= 1'b1;
      done_reg      <= 1'b0;
      tot_out_reg   <= 8'h00;
      head_reg      <= 7'h00;
      tail_reg      <= 7'h00;
      rd_reg        <= 2'h0;
      pf_reg        <= 2'h0;
      wr_reg        <= 5'h00;
      busy_reg      <= 1'b0;
      save_reg      <= 1'b0;
      loaded_reg    <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cls_reg       <= cls_next;
      long_reg      <= long_next;
      cnt_reg       <= cnt_next;
      extra_reg     <= extra_next;
      nregs_reg     <= nregs_next;
      pre_reg       <= pre_next;
      left_reg      <= left_next;
      acc_reg       <= acc_next;
      prev_tail_reg <= prev_tail_next;
      stretch_reg   <= stretch_next;
      ready_reg     <= ready_next;
      done_reg      <= done_next;
      tot_out_reg   <= tot_out_next;
      head_reg      <= head_next;
      tail_reg      <= tail_next;
      rd_reg        <= rd_next;
      pf_reg        <= pf_next;
      wr_reg        <= wr_next;
      busy_reg      <= busy_next;
      save_reg      <= save_next;
      loaded_reg    <= loaded_next;
    end
  end

  // Outputs straight from flip-flops
  assign ready_o     = ready_reg;
  assign busy_o      = busy_reg;
  assign save_step_o = save_reg;
  assign done_o      = done_reg;
  assign total_o     = tot_out_reg;
  assign head_o      = head_reg;
  assign tail_o      = tail_reg;
  assign reads_o     = rd_reg;
  assign prefetch_o  = pf_reg;
  assign writes_o    = wr_reg;

endmodule

// ==== ict_pkg.sv ====
/*
  Package for the instruction cycle timing sequencer: instruction class
  codes, per-class head/tail/total clock figures and bus cycle counts.
  Assumes a 40 MHz processor clock and two-clock operand bus accesses.
*/
package ict_pkg;

  // Instruction classes presented on the sequencer's issue port
  typedef enum logic [4:0] {
    IC_REG_ALU      = 5'h00, // Register sum, difference, compare, logic
    IC_MEM_ALU      = 5'h01, // Arithmetic or logic into memory
    IC_WORD_MUL     = 5'h02, // word_multiply
    IC_LONG_MUL32   = 5'h03, // long_multiply, 32-bit result
    IC_LONG_MUL64   = 5'h04, // long_multiply, 64-bit result
    IC_WORD_UDIV    = 5'h05, // word_unsigned_divide
    IC_WORD_SDIV    = 5'h06, // word_signed_divide
    IC_LONG_UDIV    = 5'h07, // long_unsigned_divide
    IC_LONG_SDIV    = 5'h08, // long_signed_divide
    IC_BOUNDS_CMP   = 5'h09, // bounds_compare
    IC_DEC_REG      = 5'h0A, // decimal_sum_extend between registers
    IC_DEC_MEM      = 5'h0B, // decimal_sum_extend predecremented memory
    IC_EXT_MEM      = 5'h0C, // extended_sum predecremented memory
    IC_CMP_POSTINC  = 5'h0D, // memory_compare_postinc
    IC_TAS_MEM      = 5'h0E, // test_then_set on memory
    IC_TAS_REG      = 5'h0F, // test_then_set on data_register
    IC_SHIFT_IMM    = 5'h10, // Shift or rotate by immediate count
    IC_SHIFT_MEM    = 5'h11, // Single-bit memory shift
    IC_SHIFT_REG    = 5'h12, // Register-counted shift
    IC_TBL_ROUND    = 5'h13, // table_interp_rounded, register form
    IC_TBL_SIGNED   = 5'h14, // table_interp_signed_unrounded
    IC_TBL_UNSIGNED = 5'h15, // table_interp_unsigned_unrounded
    IC_MOVEM_STRETCH= 5'h16  // Multi-register transfer, stretch tolerant
  } ict_class_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ICT_IDLE = 2'b00,
    ICT_SAVE = 2'b01,
    ICT_OPER = 2'b10
  } ict_state_t;

  // Timing basis
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned BUS_CLKS      = 2;   // Nominal bus access
  localparam int unsigned STRETCH_CLKS  = 4;   // Tolerated for transfers
  localparam logic [6:0]  LONG_EXTRA    = 7'h02;

  // Save step
  localparam logic [6:0]  SAVE_TOTAL    = 7'h03;
  localparam logic [6:0]  SAVE_HEAD     = 7'h01;
  localparam logic [6:0]  SAVE_TAIL     = 7'h01;

  // Totals (clocks)
  localparam logic [6:0]  T_REG_ALU     = 7'd2;
  localparam logic [6:0]  T_MEM_ALU     = 7'd5;
  localparam logic [6:0]  TL_MEM_ALU    = 7'd3;
  localparam logic [6:0]  T_WORD_MUL    = 7'd26;
  localparam logic [6:0]  T_LMUL_MIN    = 7'd46;
  localparam logic [6:0]  T_LMUL_MAX    = 7'd52;
  localparam logic [6:0]  T_LMUL64      = 7'd46;
  localparam logic [6:0]  T_WUDIV       = 7'd32;
  localparam logic [6:0]  T_WSDIV       = 7'd42;
  localparam logic [6:0]  T_LUDIV_MAX   = 7'd46;
  localparam logic [6:0]  T_LSDIV_MAX   = 7'd62;
  localparam logic [6:0]  T_BCMP_MIN    = 7'd16;
  localparam logic [6:0]  T_BCMP_MAX    = 7'd18;
  localparam logic [6:0]  T_DEC_REG     = 7'd4;
  localparam logic [6:0]  H_DEC_REG     = 7'd2;
  localparam logic [6:0]  T_DEC_MEM     = 7'd12;
  localparam logic [6:0]  T_EXT_MEM     = 7'd10;
  localparam logic [6:0]  HT_MEMMEM     = 7'd2;
  localparam logic [6:0]  T_MEMORY_COMPARE_POSTINC        = 7'd8;
  localparam logic [6:0]  T_TAS_MEM     = 7'd10;
  localparam logic [6:0]  T_TAS_REG     = 7'd6;
  localparam logic [6:0]  H_TAS_REG     = 7'd4;
  localparam logic [6:0]  T_SHIFT       = 7'd6;
  localparam logic [6:0]  H_SHIFT_IMM   = 7'd4;
  localparam logic [6:0]  TL_SHIFT_MEM  = 7'd2;
  localparam logic [6:0]  SHIFT_BASE    = 7'd3;
  localparam logic [5:0]  SHIFT_MAX_CNT = 6'd63;
  localparam logic [6:0]  T_TBLR_MIN    = 7'd28;
  localparam logic [6:0]  T_TBLR_MAX    = 7'd30;
  localparam logic [6:0]  T_TBLS_MIN    = 7'd30;
  localparam logic [6:0]  T_TBLS_MAX    = 7'd34;
  localparam logic [6:0]  T_TBLU_MIN    = 7'd34;
  localparam logic [6:0]  T_TBLU_MAX    = 7'd40;
  localparam logic [6:0]  H_TBLR        = 7'd26;
  localparam logic [6:0]  H_TBLSU       = 7'd30;
  localparam logic [6:0]  H_OPSTEP      = 7'd2;
  localparam logic [6:0]  T_MOVEM_BASE  = 7'd8;
  localparam logic [6:0]  T_MOVEM_PER   = 7'd4;

endpackage

// ==== ict_calc.sv ====
/*
  Combinational timing calculator: maps one instruction class and its
  qualifiers to head, tail, total clocks and read/prefetch/write counts.
  Assumes the caller holds the inputs steady while the result is used.
*/
`timescale 1ns/1ps
module ict_calc
  import ict_pkg::*;
(
  input  wire ict_class_t cls_i,
  input  wire logic       long_i,
  input  wire logic [5:0] count_i,
  input  wire logic [6:0] extra_i,
  input  wire logic [3:0] nregs_i,
  output logic       [6:0] head_o,
  output logic       [6:0] tail_o,
  output logic       [6:0] total_o,
  output logic       [1:0] reads_o,
  output logic       [1:0] pref_o,
  output logic       [4:0] writes_o
);

  // One or two bus cycles depending on operand size
  function automatic logic [1:0] size_cycles(input logic lng);
    size_cycles = lng ? 2'd2 : 2'd1;
  endfunction

  // Register-counted shift: max(6, 3 + n + parity(n + 1))
  function automatic logic [6:0] reg_shift(input logic [5:0] n);
    logic [6:0] t;
    t = SHIFT_BASE + {1'b0, n} + {6'h00, ~n[0]};
    reg_shift = (t < T_SHIFT) ? T_SHIFT : t;
  endfunction

  // Table figures are spans; the data-dependent extra is clipped to range
  function automatic logic [6:0] clip(input logic [6:0] lo,
                                      input logic [6:0] hi,
                                      input logic [6:0] ex);
    logic [7:0] s;
    s = {1'b0, lo} + {1'b0, ex};
    clip = (s > {1'b0, hi}) ? hi : s[6:0];
  endfunction

  // Per-class lookup; signed and unsigned share entries where stated
  always_comb begin
    head_o   = 7'h00;
    tail_o   = 7'h00;
    total_o  = T_REG_ALU;
    reads_o  = 2'd0;
    pref_o   = 2'd1;
    writes_o = 5'd0;
    case (cls_i)
      IC_REG_ALU: total_o = T_REG_ALU;
      IC_MEM_ALU: begin
        tail_o   = TL_MEM_ALU;
        total_o  = T_MEM_ALU;
        writes_o = {3'b000, size_cycles(long_i)};
      end
      IC_WORD_MUL: total_o = T_WORD_MUL;
      IC_LONG_MUL32: begin
        head_o  = H_OPSTEP;
        total_o = clip(T_LMUL_MIN, T_LMUL_MAX, extra_i);
      end
      IC_LONG_MUL64: begin
        head_o  = H_OPSTEP;
        total_o = T_LMUL64;
      end
      IC_WORD_UDIV: total_o = T_WUDIV;
      IC_WORD_SDIV: total_o = T_WSDIV;
      IC_LONG_UDIV: begin
        head_o  = H_OPSTEP;
        total_o = clip(7'd0, T_LUDIV_MAX, T_LUDIV_MAX - extra_i);
      end
      IC_LONG_SDIV: begin
        head_o  = H_OPSTEP;
        total_o = clip(7'd0, T_LSDIV_MAX, T_LSDIV_MAX - extra_i);
      end
      IC_BOUNDS_CMP: begin
        head_o  = H_OPSTEP;
        total_o = clip(T_BCMP_MIN, T_BCMP_MAX, extra_i);
        reads_o = size_cycles(long_i);
      end
      IC_DEC_REG: begin
        head_o  = H_DEC_REG;
        total_o = T_DEC_REG;
      end
      IC_DEC_MEM: begin
        head_o   = HT_MEMMEM;
        tail_o   = HT_MEMMEM;
        total_o  = T_DEC_MEM;
        reads_o  = 2'd2;
        writes_o = 5'd1;
      end
      IC_EXT_MEM: begin
        head_o   = HT_MEMMEM;
        tail_o   = HT_MEMMEM;
        total_o  = T_EXT_MEM;
        reads_o  = 2'd2;
        writes_o = 5'd1;
      end
      IC_CMP_POSTINC: begin
        head_o  = 7'd1;
        total_o = T_MEMORY_COMPARE_POSTINC;
        reads_o = 2'd2;
      end
      IC_TAS_MEM: begin
        head_o   = 7'd1;
        total_o  = T_TAS_MEM;
        writes_o = 5'd1;
      end
      IC_TAS_REG: begin
        head_o  = H_TAS_REG;
        total_o = T_TAS_REG;
      end
      IC_SHIFT_IMM: begin
        head_o  = H_SHIFT_IMM;
        total_o = T_SHIFT;
      end
      IC_SHIFT_MEM: begin
        tail_o   = TL_SHIFT_MEM;
        total_o  = T_SHIFT;
        writes_o = 5'd1;
      end
      IC_SHIFT_REG: begin
        total_o = reg_shift(count_i);
        head_o  = total_o;
      end
      IC_TBL_ROUND: begin
        head_o  = H_TBLR;
        pref_o  = 2'd2;
        total_o = clip(T_TBLR_MIN, T_TBLR_MAX, extra_i);
      end
      IC_TBL_SIGNED: begin
        head_o  = H_TBLSU;
        pref_o  = 2'd2;
        total_o = clip(T_TBLS_MIN, T_TBLS_MAX, extra_i);
      end
      IC_TBL_UNSIGNED: begin
        head_o  = H_TBLSU;
        pref_o  = 2'd2;
        total_o = clip(T_TBLU_MIN, T_TBLU_MAX, extra_i);
      end
      IC_MOVEM_STRETCH: begin
        head_o   = 7'd1;
        pref_o   = 2'd2;
        total_o  = T_MOVEM_BASE + T_MOVEM_PER * {3'b000, nregs_i};
        writes_o = {1'b0, nregs_i};
      end
      default: total_o = T_REG_ALU;
    endcase
    // Long operands add two clocks to tail and total for x-sized classes
    if (long_i && (cls_i == IC_MEM_ALU || cls_i == IC_BOUNDS_CMP)) begin
      tail_o  = tail_o + LONG_EXTRA;
      total_o = total_o + LONG_EXTRA;
    end
  end

endmodule

// ==== ict_seq_assertions.sv ====
/*
  Checker for the instruction cycle timing sequencer ports.
  Assumes it is bound to the sequencer and sees only its ports.
*/
`timescale 1ns/1ps
module ict_seq_assertions
  import ict_pkg::*;
(
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire logic       issue_i,
  input wire logic [4:0] class_i,
  input wire logic       src_data_reg_i,
  input wire logic       mem_form_i,
  input wire logic [6:0] ea_clocks_i,
  input wire logic       bus_wait_i,
  input wire logic       ready_o,
  input wire logic       busy_o,
  input wire logic       save_step_o,
  input wire logic       done_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Accepted issue, then a save step of exactly three clocks
  sequence take_s;
    issue_i && ready_o;
  endsequence
  sequence save_s;
    save_step_o [*3] ##1 !save_step_o;
  endsequence

  busy_ready_a: assert property (busy_o == !ready_o)
    else $error("busy and ready disagree");
  take_busy_a: assert property (take_s |=> busy_o)
    else $error("accepted issue did not start");
  busy_cause_a: assert property ($rose(busy_o) |-> $past(issue_i))
    else $error("busy without an issue");
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  done_ready_a: assert property (done_o |->
    ready_o && !$past(ready_o)) else $error("done not at end of a run");
  save_len_a: assert property ($rose(save_step_o) |-> save_s)
    else $error("save step not three clocks");
  save_skip_a: assert property ((issue_i && ready_o &&
    src_data_reg_i && class_i == IC_LONG_MUL64) |=> !save_step_o [*4])
    else $error("save step with data register source");
  alu_time_a: assert property ((issue_i && ready_o && !mem_form_i &&
    class_i == IC_REG_ALU && ea_clocks_i == 7'h00) ##1 !bus_wait_i [*4]
    |-> done_o) else $error("register operation not two clocks");
  idle_save_a: assert property (ready_o |-> !save_step_o)
    else $error("save step while idle");
endmodule

// ==== ict_mem_model.sv ====
/*
  Memory bus model: answers in two clocks, or in four when slow_i is
  set, shown as two wait cycles early in each instruction.
  Assumes busy_i marks a running instruction.
*/
`timescale 1ns/1ps
module ict_mem_model (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic busy_i,
  input  wire logic slow_i,
  output logic      bus_wait_o
);
  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;

  // Busy cycle count, cleared between instructions
  always_comb begin
    cnt_next = busy_i ? cnt_reg + 7'h01 : 7'h00;
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // One slow access only, so the added time is known exactly
  assign bus_wait_o = slow_i && busy_i && cnt_reg[6:1] == 6'h01;
endmodule

// ==== tb.sv ====
/*
  Testbench: issues each class, counts clocks to done, checks figures.
  Assumes the memory bus model drives the bus wait input.
*/
`timescale 1ns/1ps
bind ict_sequencer ict_seq_assertions ict_seq_assertions_inst (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .issue_i(issue_i),
  .class_i(class_i), .src_data_reg_i(src_data_reg_i),
  .mem_form_i(mem_form_i), .ea_clocks_i(ea_clocks_i),
  .bus_wait_i(bus_wait_i), .ready_o(ready_o), .busy_o(busy_o),
  .save_step_o(save_step_o), .done_o(done_o));
module tb
  import ict_pkg::*;
;
  logic       ref_clk_i, rst_n_i, issue_i, long_op_i, src_data_reg_i;
  logic       mem_form_i, bus_wait_i, slow, ready_o, busy_o;
  logic       save_step_o, done_o;
  logic [4:0] class_i, writes_o;
  logic [5:0] shift_count_i;
  logic [6:0] data_extra_i, ea_clocks_i, imm_clocks_i, head_o, tail_o;
  logic [3:0] reg_count_i;
  logic [7:0] total_o;
  logic [1:0] reads_o, prefetch_o;
  int         n_fail, checks, cyc, prev;

  ict_sequencer ict_sequencer_inst (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .issue_i(issue_i), .class_i(class_i),
    .long_op_i(long_op_i), .src_data_reg_i(src_data_reg_i),
    .mem_form_i(mem_form_i), .shift_count_i(shift_count_i),
    .data_extra_i(data_extra_i), .ea_clocks_i(ea_clocks_i),
    .imm_clocks_i(imm_clocks_i), .reg_count_i(reg_count_i),
    .bus_wait_i(bus_wait_i), .ready_o(ready_o), .busy_o(busy_o),
    .save_step_o(save_step_o), .done_o(done_o), .total_o(total_o),
    .head_o(head_o), .tail_o(tail_o), .reads_o(reads_o),
    .prefetch_o(prefetch_o), .writes_o(writes_o));
  ict_mem_model ict_mem_model_inst (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .busy_i(busy_o), .slow_i(slow),
    .bus_wait_o(bus_wait_i));

  // 40 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %0d expected %0d", $time, got, exp);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Issue one instruction; expected clocks from figures, overlap, waits
  task automatic run(input logic [4:0] c, input logic lg, sr,
    input int sh, ex, ea, im, wt, t, h, tl, r, p, w, sv);
    int ov, e, k;
    ov = (prev < h) ? prev : h;
    e = t + ea + im - ov;
    if (e < 1) e = 1;
    e = e + 1 + wt + (sv ? 3 : 0);
    @(posedge ref_clk_i);
    issue_i <= 1'b1; class_i <= c; long_op_i <= lg;
    src_data_reg_i <= sr; mem_form_i <= (im != 0);
    shift_count_i <= 6'(sh); reg_count_i <= 4'(sh);
    data_extra_i <= 7'(ex); ea_clocks_i <= 7'(ea); imm_clocks_i <= 7'(im);
    @(posedge ref_clk_i);
    issue_i <= 1'b0;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      #1 k++;
    end while (done_o !== 1'b1 && k < 250);
    chk(k[7:0], e[7:0]);
    chk(total_o, 8'(e - 1));
    chk({7'h00, ready_o}, 8'h01);
    chk({1'b0, head_o}, h[7:0]);
    chk({1'b0, tail_o}, tl[7:0]);
    chk({6'h00, reads_o}, r[7:0]);
    chk({6'h00, prefetch_o}, p[7:0]);
    chk({3'h0, writes_o}, w[7:0]);
    prev = tl;
  endtask

  task t_alu;
    run(IC_REG_ALU,0,0,0,0,0,0,0, 2,0,0,0,1,0,0);
    run(IC_MEM_ALU,0,0,0,0,0,0,0, 5,0,3,0,1,1,0);
    run(IC_TAS_REG,0,0,0,0,0,0,0, 6,4,0,0,1,0,0);
    run(IC_MEM_ALU,1,0,0,0,0,0,0, 7,0,5,0,1,2,0);
    run(IC_REG_ALU,0,0,0,0,0,4,0, 2,0,0,0,1,0,0);
    run(IC_MEM_ALU,0,0,0,0,2,3,0, 5,0,3,0,1,1,0);
  endtask

  task t_muldiv;
    run(IC_WORD_MUL,0,0,0,0,3,0,0, 26,0,0,0,1,0,0);
    run(IC_WORD_UDIV,0,0,0,0,0,0,0, 32,0,0,0,1,0,0);
    run(IC_WORD_SDIV,0,0,0,0,0,0,0, 42,0,0,0,1,0,0);
    run(IC_LONG_MUL32,0,1,0,0,0,0,0, 46,2,0,0,1,0,0);
    run(IC_LONG_MUL32,0,1,0,127,0,0,0, 52,2,0,0,1,0,0);
    run(IC_LONG_MUL64,0,0,0,0,0,0,0, 46,2,0,0,1,0,1);
    run(IC_LONG_MUL64,0,1,0,0,0,0,0, 46,2,0,0,1,0,0);
    run(IC_LONG_UDIV,0,1,0,0,0,0,0, 46,2,0,0,1,0,0);
    run(IC_LONG_SDIV,0,1,0,0,0,0,0, 62,2,0,0,1,0,0);
    run(IC_LONG_SDIV,0,1,0,10,0,0,0, 52,2,0,0,1,0,0);
  endtask

  task t_misc;
    run(IC_DEC_REG,0,0,0,0,0,0,0, 4,2,0,0,1,0,0);
    run(IC_DEC_MEM,0,0,0,0,0,0,0, 12,2,2,2,1,1,0);
    run(IC_DEC_REG,0,0,0,0,0,0,0, 4,2,0,0,1,0,0);
    run(IC_EXT_MEM,0,0,0,0,0,0,0, 10,2,2,2,1,1,0);
    run(IC_CMP_POSTINC,0,0,0,0,0,0,0, 8,1,0,2,1,0,0);
    run(IC_TAS_MEM,0,0,0,0,0,0,0, 10,1,0,0,1,1,0);
    run(IC_BOUNDS_CMP,1,0,0,1,0,0,0, 19,2,2,2,1,0,1);
  endtask

  task t_shift;
    run(IC_SHIFT_IMM,0,0,0,0,0,0,0, 6,4,0,0,1,0,0);
    run(IC_SHIFT_MEM,0,0,0,0,0,0,0, 6,0,2,0,1,1,0);
    run(IC_SHIFT_REG,0,0,0,0,0,0,0, 6,6,0,0,1,0,0);
    run(IC_SHIFT_REG,0,0,4,0,0,0,0, 8,8,0,0,1,0,0);
    run(IC_SHIFT_REG,0,0,63,0,0,0,0, 66,66,0,0,1,0,0);
    run(IC_SHIFT_REG,0,0,1,0,0,0,0, 6,6,0,0,1,0,0);
    run(IC_TBL_ROUND,0,0,0,0,0,0,0, 28,26,0,0,2,0,0);
    run(IC_TBL_SIGNED,0,0,0,0,0,0,0, 30,30,0,0,2,0,0);
    run(IC_TBL_UNSIGNED,0,0,0,0,0,0,0, 34,30,0,0,2,0,0);
  endtask

  // Slow memory lengthens plain classes, not stretch-tolerant ones
  task t_slow;
    @(posedge ref_clk_i);
    slow <= 1'b1;
    run(IC_WORD_MUL,0,0,0,0,0,0,2, 26,0,0,0,1,0,0);
    run(IC_MOVEM_STRETCH,0,0,2,0,0,0,0, 16,1,0,0,2,2,0);
  endtask

  // Cut a hang short
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    rst_n_i = 1'b0; issue_i = 1'b0; class_i = 5'h00; long_op_i = 1'b0;
    src_data_reg_i = 1'b0; mem_form_i = 1'b0; shift_count_i = 6'h00;
    data_extra_i = 7'h00; ea_clocks_i = 7'h00; imm_clocks_i = 7'h00;
    reg_count_i = 4'h0; slow = 1'b0; prev = 0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_alu();
    t_muldiv();
    t_misc();
    t_shift();
    t_slow();
    results();
  end
endmodule
